// *** common/ect_map.svh ***
// Register indices, field positions and reset values of the capture timer
`ifndef ECT_MAP_SVH
`define ECT_MAP_SVH
// Register indices; byte address is four times the index
`define ECT_IX_DIR    8'h80
`define ECT_IX_FORCE  8'h81
`define ECT_IX_MASK7  8'h82
`define ECT_IX_DATA7  8'h83
`define ECT_IX_CNT    8'h84
`define ECT_IX_SYS    8'h86
`define ECT_IX_ACTHI  8'h88
`define ECT_IX_ACTLO  8'h89
`define ECT_IX_CHFLG  8'h8E
`define ECT_IX_OVFLG  8'h8F
`define ECT_IX_TC0    8'h90
`define ECT_IX_AFLG   8'hA1
`define ECT_IX_PA3    8'hA2
`define ECT_IX_MCTL   8'hA6
`define ECT_IX_MFLG   8'hA7
`define ECT_IX_NOVW   8'hAA
`define ECT_IX_CSYS   8'hAB
`define ECT_IX_PDAT   8'hAE
`define ECT_IX_PDIR   8'hAF
`define ECT_IX_BFLG   8'hB1
`define ECT_IX_PH3    8'hB2
`define ECT_IX_MCNT   8'hB6
`define ECT_IX_HLD0   8'hB8
// Field positions
`define ECT_SYS_RUN   7
`define ECT_SYS_WAIT  6
`define ECT_SYS_BGD   5
`define ECT_SYS_FAST  4
`define ECT_CS_PAIRA  7
`define ECT_CS_PAIRB  6
`define ECT_CS_SAT    1
`define ECT_CS_LATCH_QUEUE_SELECT   0
`define ECT_MC_FLAT   4
`define ECT_MC_EN     2
`define ECT_MC_ONCE   1
`define ECT_FLG_HI    7
`define ECT_FLG_PAOV  1
// Values
`define ECT_RST8      8'h00
`define ECT_RST16     16'h0000
`define ECT_PA_MAX    8'hFF
`define ECT_CNT_MAX   16'hFFFF
`define ECT_ONE16     16'h0001
`define ECT_PA_ONE    8'h01
`define ECT_DIV_LAST  6'h3F
`define ECT_OE_RST    8'hFF
`endif

// *** common/ect_pkg.sv ***
// Shared types of the capture timer
package ect_pkg;
  typedef enum logic [1:0] {
    ACT_OFF = 2'h0,
    ACT_TGL = 2'h1,
    ACT_CLR = 2'h2,
    ACT_SET = 2'h3
  } ect_act_t;
  typedef logic [15:0] ect_word_t;
endpackage : ect_pkg

// *** rtl/ect_core.sv ***
// Eight-channel capture/compare timer core with APB register access
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "ect_map.svh"
module ect_core (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Chip mode
  input  wire logic        waitMode,
  input  wire logic        bgdMode,
  input  wire logic        specialModeN,
  // Timer port pins
  input  wire logic [7:0]  tpIn,
  output logic      [7:0]  tpOut,
  output logic      [7:0]  tpOeN
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  dir_q, mask7_q, data7_q, sys_q, novw_q, csys_q, mctl_q;
  logic [7:0]  pdat_q, pdir_q, chFlg_q, inPrev_q, pinLat_q, capFull_q;
  logic [15:0] act_q, cnt_q, modCnt_q, modLoad_q;
  logic [15:0] tc_q [8];
  logic [15:0] hold_q [4];
  logic [7:0]  pacc_q [4];
  logic [7:0]  paHold_q [4];
  logic [3:0]  hldFull_q;
  logic        ovf_q, aOv_q, bOv_q, mZero_q;
  logic [5:0]  presc_q;
  logic        preadyQ, pslverrQ;
  logic [31:0] prdataQ;

  function automatic logic actFn(input logic [1:0] code, input logic cur);
    unique case (ect_pkg::ect_act_t'(code))
      ect_pkg::ACT_OFF: actFn = cur;
      ect_pkg::ACT_TGL: actFn = ~cur;
      ect_pkg::ACT_CLR: actFn = 1'b0;
      ect_pkg::ACT_SET: actFn = 1'b1;
    endcase
  endfunction : actFn

  function automatic logic [7:0] ixOf(input logic [7:0] base,
                                      input logic [2:0] n);
    ixOf = base + {4'h0, n, 1'b0};
  endfunction : ixOf

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode; a transfer acts at the edge where pready is sampled high
  wire        acc  = psel & penable & preadyQ;
  wire        wr   = acc & pwrite;
  wire        rd   = acc & ~pwrite;
  wire        look = psel & penable & ~preadyQ;
  wire [7:0]  idx  = paddr[9:2];
  wire [15:0] wd   = pwdata[15:0];
  wire        fast = sys_q[`ECT_SYS_FAST];
  wire        latch_queue_select = csys_q[`ECT_CS_LATCH_QUEUE_SELECT];
  wire        sat  = csys_q[`ECT_CS_SAT];
  wire        pairA = csys_q[`ECT_CS_PAIRA];
  wire        pairB = csys_q[`ECT_CS_PAIRB];
  wire        cntHit = idx == `ECT_IX_CNT;
  wire        wrCnt = wr & cntHit & ~specialModeN;
  wire        mcHit = idx == `ECT_IX_MCNT;
  wire        wrMc  = wr & mcHit;
  wire        wrMctl = wr & (idx == `ECT_IX_MCTL);
  wire [7:0]  frc = (wr && idx == `ECT_IX_FORCE) ? wd[7:0] : `ECT_RST8;
  logic [7:0] tcSel;
  logic [3:0] hlSel, paSel, phSel;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      tcSel[i] = idx == ixOf(`ECT_IX_TC0, 3'(i));
    end
    for (int i = 0; i < 4; i++) begin
      hlSel[i] = idx == ixOf(`ECT_IX_HLD0, 3'(i));
      paSel[i] = idx == `ECT_IX_PA3 + 8'(3 - i);
      phSel[i] = idx == `ECT_IX_PH3 + 8'(3 - i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run gating and timebases
  wire waitHalt = waitMode & sys_q[`ECT_SYS_WAIT];
  wire tmrRun = sys_q[`ECT_SYS_RUN] & ~waitHalt
              & ~(bgdMode & sys_q[`ECT_SYS_BGD]);
  wire paRun  = ~waitHalt;
  // Divide-by-64 only exists while the timer runs
  wire div64 = tmrRun & (presc_q == `ECT_DIV_LAST);
  wire modTick = div64 & mctl_q[`ECT_MC_EN];
  wire modZeroEv = modTick & (modCnt_q == `ECT_ONE16);
  wire latchEv = modZeroEv | (wrMc & (wd == `ECT_RST16))
               | (wrMctl & wd[`ECT_MC_FLAT]);

  ////////////////////////////////////////////////////////////////////////////
  // Channel events
  wire [7:0] rise  = tpIn & ~inPrev_q;
  wire [7:0] capEv = rise & ~dir_q;
  logic [7:0] cmpHit;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      cmpHit[i] = dir_q[i] & tmrRun & (tc_q[i] == cnt_q);
    end
  end
  wire [7:0] actEv = cmpHit | (frc & dir_q);
  wire       oc7Ev = actEv[7];
  wire [7:0] owns  = (mask7_q & dir_q) | {
    |act_q[15:14], |act_q[13:12], |act_q[11:10], |act_q[9:8],
    |act_q[7:6], |act_q[5:4], |act_q[3:2], |act_q[1:0]};

  // Buffered capture moves: latch event or queue shift
  logic [3:0] mv, hlRd;
  logic [7:0] ld;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ld[i] = capEv[i] & (~novw_q[i] | ~capFull_q[i]);
    end
    for (int i = 0; i < 4; i++) begin
      hlRd[i] = rd & hlSel[i];
      mv[i] = ~dir_q[i] & (latch_queue_select
        ? latchEv & (~novw_q[i] | ~hldFull_q[i])
        : capEv[i] & (~novw_q[i] | (capFull_q[i] & ~hldFull_q[i])));
      ld[i] = capEv[i] & (~novw_q[i] | ~capFull_q[i] | mv[i]);
    end
  end

  // Accumulator increments; pairs carry low into high
  logic [3:0] rawInc, paInc, paClr, paFull;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      paFull[i] = pacc_q[i] == `ECT_PA_MAX;
    end
    rawInc[0] = rise[0] & paRun;
    rawInc[2] = rise[2] & paRun;
    paInc[0] = rawInc[0] & ~(sat & ~pairB & paFull[0]);
    paInc[2] = rawInc[2] & ~(sat & ~pairA & paFull[2]);
    rawInc[1] = pairB ? paInc[0] & paFull[0] : rise[1] & paRun;
    rawInc[3] = pairA ? paInc[2] & paFull[2] : rise[3] & paRun;
    paInc[1] = rawInc[1] & ~(sat & ~pairB & paFull[1]);
    paInc[3] = rawInc[3] & ~(sat & ~pairA & paFull[3]);
    paClr = latch_queue_select ? {4{latchEv}} : hlRd;
  end

  // Flag set and clear; a set in the clear cycle wins
  wire [7:0] chClr = ((wr && idx == `ECT_IX_CHFLG) ? wd[7:0] : `ECT_RST8)
                   | ({8{fast & rd}} & tcSel & ~dir_q)
                   | ({8{fast & wr}} & tcSel & dir_q);
  wire ovClr = (wr & (idx == `ECT_IX_OVFLG) & wd[`ECT_FLG_HI])
             | (fast & acc & cntHit);
  wire aClr = (wr & (idx == `ECT_IX_AFLG) & wd[`ECT_FLG_PAOV])
            | (fast & acc & (paSel[3] | paSel[2]));
  wire bClr = (wr & (idx == `ECT_IX_BFLG) & wd[`ECT_FLG_PAOV])
            | (fast & acc & (paSel[1] | paSel[0]));
  wire mClr = (wr & (idx == `ECT_IX_MFLG) & wd[`ECT_FLG_HI])
            | (fast & acc & mcHit);
  wire ovSet = tmrRun & ~wrCnt & (cnt_q == `ECT_CNT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_q <= `ECT_RST8;   mask7_q <= `ECT_RST8; data7_q <= `ECT_RST8;
      sys_q <= `ECT_RST8;   novw_q <= `ECT_RST8;  csys_q <= `ECT_RST8;
      mctl_q <= `ECT_RST8;  pdat_q <= `ECT_RST8;  pdir_q <= `ECT_RST8;
      act_q <= `ECT_RST16;
    end else if (wr) begin
      if (idx == `ECT_IX_DIR)   dir_q <= wd[7:0];
      if (idx == `ECT_IX_MASK7) mask7_q <= wd[7:0];
      if (idx == `ECT_IX_DATA7) data7_q <= wd[7:0];
      if (idx == `ECT_IX_SYS)   sys_q <= wd[7:0];
      if (idx == `ECT_IX_NOVW)  novw_q <= wd[7:0];
      if (idx == `ECT_IX_CSYS)  csys_q <= wd[7:0];
      if (idx == `ECT_IX_PDAT)  pdat_q <= wd[7:0];
      if (idx == `ECT_IX_PDIR)  pdir_q <= wd[7:0];
      if (idx == `ECT_IX_ACTHI) act_q[15:8] <= wd[7:0];
      if (idx == `ECT_IX_ACTLO) act_q[7:0] <= wd[7:0];
      if (wrMctl) mctl_q <= wd[7:0] & ~(8'h01 << `ECT_MC_FLAT);
    end
  end

  // Main counter, prescaler, modulus counter, flags
  always_ff @(posedge clk_sys) begin
    // Tracks the pin in reset too, so a pin high at release is no edge
    inPrev_q <= tpIn;
    if (sys_rst) begin
      cnt_q <= `ECT_RST16; presc_q <= '0; modCnt_q <= `ECT_RST16;
      modLoad_q <= `ECT_RST16; chFlg_q <= `ECT_RST8;
      ovf_q <= 1'b0; aOv_q <= 1'b0; bOv_q <= 1'b0; mZero_q <= 1'b0;
    end else begin
      if (wrCnt) cnt_q <= wd;
      else if (tmrRun) cnt_q <= cnt_q + `ECT_ONE16;
      if (tmrRun) presc_q <= presc_q + 6'h01;
      if (wrMc) begin
        modLoad_q <= wd;
        modCnt_q <= wd;
      end else if (modTick) begin
        if (modCnt_q != `ECT_RST16) modCnt_q <= modCnt_q - `ECT_ONE16;
        else if (!mctl_q[`ECT_MC_ONCE]) modCnt_q <= modLoad_q;
      end
      chFlg_q <= (chFlg_q & ~chClr) | capEv | cmpHit;
      ovf_q   <= (ovf_q & ~ovClr) | ovSet;
      aOv_q   <= (aOv_q & ~aClr) | (paInc[3] & paFull[3]);
      bOv_q   <= (bOv_q & ~bClr) | (paInc[1] & paFull[1]);
      mZero_q <= (mZero_q & ~mClr) | modZeroEv;
    end
  end

  // Capture, holding and accumulator storage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      capFull_q <= `ECT_RST8;
      hldFull_q <= '0;
      for (int i = 0; i < 8; i++) tc_q[i] <= `ECT_RST16;
      for (int i = 0; i < 4; i++) begin
        hold_q[i] <= `ECT_RST16;
        pacc_q[i] <= `ECT_RST8;
        paHold_q[i] <= `ECT_RST8;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (rd & tcSel[i] & ~dir_q[i]) capFull_q[i] <= 1'b0;
        if (wr & tcSel[i] & dir_q[i]) tc_q[i] <= wd;
      end
      for (int i = 0; i < 4; i++) begin
        if (hlRd[i]) hldFull_q[i] <= 1'b0;
        if (mv[i]) begin
          hold_q[i] <= tc_q[i];
          hldFull_q[i] <= capFull_q[i];
          capFull_q[i] <= 1'b0;
        end
        if (paClr[i]) begin
          paHold_q[i] <= pacc_q[i];
          pacc_q[i] <= paInc[i] ? `ECT_PA_ONE : `ECT_RST8;
        end else if (paInc[i]) begin
          pacc_q[i] <= pacc_q[i] + `ECT_PA_ONE;
        end
      end
      for (int i = 0; i < 8; i++) begin
        if (ld[i]) begin
          tc_q[i] <= cnt_q;
          capFull_q[i] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin latch and pin drivers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pinLat_q <= `ECT_RST8;
      tpOut <= `ECT_RST8;
      tpOeN <= `ECT_OE_RST;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (oc7Ev & mask7_q[i]) pinLat_q[i] <= data7_q[i];
        else if (actEv[i] & ~mask7_q[i])
          pinLat_q[i] <= actFn(act_q[2*i +: 2], pinLat_q[i]);
      end
      tpOut <= (owns & pinLat_q) | (~owns & pdat_q);
      tpOeN <= ~(owns | pdir_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data; one wait state so all answers come from flip-flops
  logic [15:0] rdv;
  logic        mapped;
  always_comb begin
    rdv = `ECT_RST16;
    mapped = 1'b1;
    unique case (idx)
      `ECT_IX_DIR:   rdv = {8'h00, dir_q};
      `ECT_IX_FORCE: rdv = `ECT_RST16;
      `ECT_IX_MASK7: rdv = {8'h00, mask7_q};
      `ECT_IX_DATA7: rdv = {8'h00, data7_q};
      `ECT_IX_CNT:   rdv = cnt_q;
      `ECT_IX_SYS:   rdv = {8'h00, sys_q};
      `ECT_IX_ACTHI: rdv = {8'h00, act_q[15:8]};
      `ECT_IX_ACTLO: rdv = {8'h00, act_q[7:0]};
      `ECT_IX_CHFLG: rdv = {8'h00, chFlg_q};
      `ECT_IX_OVFLG: rdv = {8'h00, ovf_q, 7'h00};
      `ECT_IX_AFLG:  rdv = {14'h0000, aOv_q, 1'b0};
      `ECT_IX_MCTL:  rdv = {8'h00, mctl_q};
      `ECT_IX_MFLG:  rdv = {8'h00, mZero_q, 7'h00};
      `ECT_IX_NOVW:  rdv = {8'h00, novw_q};
      `ECT_IX_CSYS:  rdv = {8'h00, csys_q};
      `ECT_IX_PDAT:  rdv = {8'h00, pdat_q};
      `ECT_IX_PDIR:  rdv = {8'h00, pdir_q};
      `ECT_IX_BFLG:  rdv = {14'h0000, bOv_q, 1'b0};
      `ECT_IX_MCNT:  rdv = modCnt_q;
      default:       mapped = 1'b0;
    endcase
    for (int i = 0; i < 8; i++) begin
      if (tcSel[i]) begin
        rdv = tc_q[i];
        mapped = 1'b1;
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (hlSel[i]) rdv = hold_q[i];
      if (paSel[i]) rdv = {8'h00, pacc_q[i]};
      if (phSel[i]) rdv = {8'h00, paHold_q[i]};
      if (hlSel[i] | paSel[i] | phSel[i]) mapped = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      preadyQ <= 1'b0;
      pslverrQ <= 1'b0;
      prdataQ <= '0;
    end else begin
      preadyQ <= look;
      pslverrQ <= look & ~mapped;
      if (look & ~pwrite) prdataQ <= {16'h0000, rdv};
    end
  end
  assign pready = preadyQ;
  assign pslverr = pslverrQ;
  assign prdata = prdataQ;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence sAccClr0;
    paClr[0] && !paInc[0];
  endsequence
  property pAccMove;
    sAccClr0 |=> paHold_q[0] == $past(pacc_q[0]) && pacc_q[0] == `ECT_RST8;
  endproperty

  chk_acc_move_clear: assert property (pAccMove)
    else $error("accumulator not moved and cleared");
  chk_count_halt: assert property (!tmrRun && !wrCnt |=> $stable(cnt_q))
    else $error("counter moved while halted");
  chk_count_normal_wr: assert property (
    wr && cntHit && specialModeN
    |=> cnt_q == $past(cnt_q) + {15'h0000, $past(tmrRun)})
    else $error("counter write taken in normal mode");
  chk_force_reads_zero: assert property (
    look && !pwrite && idx == `ECT_IX_FORCE |=> prdata == 32'h0)
    else $error("force register read nonzero");
  chk_guard_keeps_cap: assert property (
    capEv[5] && novw_q[5] && capFull_q[5] && !dir_q[5]
    |=> tc_q[5] == $past(tc_q[5]))
    else $error("guarded capture overwritten");
  chk_cap_overwrite: assert property (
    capEv[5] && !novw_q[5] |=> tc_q[5] == $past(cnt_q))
    else $error("capture did not take counter");
  chk_queue_shift: assert property (
    !latch_queue_select && capEv[1] && !novw_q[1] |=> hold_q[1] == $past(tc_q[1])
      ##0 tc_q[1] == $past(cnt_q))
    else $error("queue shift wrong");
  chk_latch_copy: assert property (
    latch_queue_select && latchEv && !novw_q[1] && !dir_q[1]
    |=> hold_q[1] == $past(tc_q[1]) ##0 (!capFull_q[1] || $past(ld[1])))
    else $error("latch copy wrong");
  chk_sat_hold: assert property (
    sat && !pairA && paFull[2] && !paClr[2] |=> paFull[2])
    else $error("saturated accumulator wrapped");
  chk_oc7_prio: assert property (
    oc7Ev && mask7_q[6] |=> pinLat_q[6] == $past(data7_q[6]))
    else $error("channel 7 data not applied");
  chk_flag_set_wins: assert property (capEv[5] |=> chFlg_q[5])
    else $error("capture flag lost");
endmodule : ect_core

// *** sim/ect_core_test.sv ***
// Register-level bench of the capture timer core
`timescale 1ns/1ps
module ect_core_test;
  logic        clk_sys;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [9:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        waitMode;
  logic        bgdMode;
  logic        specialModeN;
  logic [7:0]  tpIn;
  logic [7:0]  tpOut;
  logic [7:0]  tpOeN;
  logic [15:0] rdQ;
  logic        errQ;
  int          bad_count;
  int          checked;
  int          cycles = 0;
  logic [1:0]  codes [4] = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic        outs  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  ect_core ect_core_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .waitMode(waitMode), .bgdMode(bgdMode),
    .specialModeN(specialModeN), .tpIn(tpIn), .tpOut(tpOut),
    .tpOeN(tpOeN)
  );
  ect_pin_model ect_pin_model_inst (
    .clk_sys(clk_sys), .tpOut(tpOut), .tpOeN(tpOeN), .tpIn(tpIn)
  );

  always #12.5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Slave answer time is not assumed; only the bound ends a wait
  task automatic xfer(input logic w, input logic [7:0] ix,
                      input logic [15:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {ix, 2'h0};
    pwdata  <= {16'h0000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdQ     = prdata[15:0];
    errQ    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] ix, input logic [15:0] d);
    xfer(1'b1, ix, d);
  endtask : wr

  task automatic rdc(input logic [7:0] ix, input logic [15:0] exp);
    xfer(1'b0, ix, 16'h0000);
    chk(rdQ, exp);
  endtask : rdc

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : idle

  // Counter is stopped, so a capture takes exactly the loaded value
  task automatic capAt(input logic [15:0] v, input int n);
    wr(8'h84, v);
    ect_pin_model_inst.pulse(n);
  endtask : capAt

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0; sys_rst = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 10'h000; pwdata = 32'h0; waitMode = 1'b0;
    bgdMode = 1'b0; specialModeN = 1'b1; bad_count = 0; checked = 0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rdc(8'h81, 16'h0000);
    rdc(8'h83, 16'h0000);
    rdc(8'h84, 16'h0000);
    chk({8'h00, tpOeN}, 16'h00FF);
    rdc(8'h00, 16'h0000);
    chk({15'h0, errQ}, 16'h0001);
    $display("test reset done");
    wr(8'h84, 16'h1111);
    rdc(8'h84, 16'h0000);
    specialModeN <= 1'b0;
    wr(8'h84, 16'h1234);
    idle(5);
    rdc(8'h84, 16'h1234);
    $display("test counter done");
    wr(8'h86, 16'h0010);
    wr(8'h8E, 16'h00FF);
    wr(8'hAA, 16'h0020);
    capAt(16'h0100, 5);
    capAt(16'h0200, 5);
    rdc(8'h8E, 16'h0020);
    rdc(8'h9A, 16'h0100);
    rdc(8'h8E, 16'h0000);
    wr(8'hAA, 16'h0000);
    capAt(16'h0300, 5);
    capAt(16'h0400, 5);
    rdc(8'h9A, 16'h0400);
    $display("test unbuffered done");
    wr(8'hAB, 16'h0001);
    capAt(16'h0500, 0);
    wr(8'hA6, 16'h0010);
    rdc(8'hB8, 16'h0500);
    rdc(8'hB5, 16'h0001);
    rdc(8'hA5, 16'h0000);
    capAt(16'h0600, 0);
    capAt(16'h0700, 0);
    wr(8'hB6, 16'h0000);
    rdc(8'hB8, 16'h0700);
    rdc(8'hB5, 16'h0002);
    $display("test latch done");
    wr(8'hAB, 16'h0000);
    capAt(16'h0800, 1);
    capAt(16'h0900, 1);
    rdc(8'h92, 16'h0900);
    rdc(8'hBA, 16'h0800);
    rdc(8'hB4, 16'h0002);
    rdc(8'hA4, 16'h0000);
    wr(8'hAA, 16'h0004);
    capAt(16'h0A00, 2);
    capAt(16'h0B00, 2);
    capAt(16'h0C00, 2);
    rdc(8'h94, 16'h0B00);
    rdc(8'hBC, 16'h0A00);
    $display("test queue done");
    wr(8'hAB, 16'h0002);
    repeat (300) ect_pin_model_inst.pulse(2);
    rdc(8'hA3, 16'h00FF);
    wr(8'hAB, 16'h0082);
    ect_pin_model_inst.pulse(2);
    rdc(8'hA2, 16'h0001);
    rdc(8'hA3, 16'h0000);
    rdc(8'hBE, 16'h0000);
    wr(8'hAB, 16'h0002);
    $display("test saturate done");
    wr(8'h80, 16'h00D0);
    rdc(8'h80, 16'h00D0);
    wr(8'h8E, 16'h00FF);
    for (int i = 0; i < 4; i++) begin
      wr(8'h88, {14'h0, codes[i]});
      wr(8'h81, 16'h0010);
      idle(3);
      chk({15'h0, tpOut[4]}, {15'h0, outs[i]});
      chk({15'h0, tpOeN[4]}, 16'h0000);
    end
    rdc(8'h8E, 16'h0000);
    wr(8'h88, 16'h0000);
    idle(3);
    chk({15'h0, tpOeN[4]}, 16'h0001);
    $display("test force done");
    wr(8'h82, 16'h0040);
    wr(8'h88, 16'h0030);
    wr(8'h81, 16'h0040);
    idle(3);
    chk({15'h0, tpOeN[6]}, 16'h0000);
    chk({15'h0, tpOut[6]}, 16'h0000);
    wr(8'h81, 16'h00C0);
    idle(3);
    chk({15'h0, tpOut[6]}, 16'h0000);
    wr(8'h83, 16'h0040);
    wr(8'h81, 16'h0080);
    idle(3);
    chk({15'h0, tpOut[6]}, 16'h0001);
    $display("test mask7 done");
    wr(8'h86, 16'h0080);
    wr(8'hA6, 16'h0004);
    wr(8'hB6, 16'h0002);
    idle(200);
    rdc(8'hA7, 16'h0080);
    $display("test modulus done");
    wr(8'h86, 16'h00C0);
    waitMode <= 1'b1;
    wr(8'h84, 16'h2222);
    ect_pin_model_inst.pulse(3);
    idle(10);
    rdc(8'h84, 16'h2222);
    rdc(8'hA2, 16'h0000);
    waitMode <= 1'b0;
    wr(8'h86, 16'h00A0);
    bgdMode <= 1'b1;
    wr(8'h84, 16'h3333);
    ect_pin_model_inst.pulse(3);
    ect_pin_model_inst.pulse(3);
    rdc(8'h84, 16'h3333);
    rdc(8'hA2, 16'h0002);
    $display("test stop modes done");
    tally_and_finish;
  end
endmodule : ect_core_test

// *** sim/ect_pin_model.sv ***
// Timer port pin model: edge pulses in, driven pins read back
`timescale 1ns/1ps
module ect_pin_model (
  // Clock
  input  wire logic       clk_sys,
  // Device side of the pins
  input  wire logic [7:0] tpOut,
  input  wire logic [7:0] tpOeN,
  output logic      [7:0] tpIn
);
  logic [7:0] drvQ;
  initial drvQ = 8'h00;
  // A pin the timer drives shows its own level, not the stale pulse
  assign tpIn = (tpOeN & drvQ) | (~tpOeN & tpOut);
  ////////////////////////////////////////////////////////////////
  task automatic pulse(input int n);
    @(posedge clk_sys);
    drvQ[n] <= 1'b1;
    @(posedge clk_sys);
    drvQ[n] <= 1'b0;
  endtask : pulse
endmodule : ect_pin_model
